// ---- rtl/sbpm_pkg.sv ----
// How it works
// (R1) 25-bit deep standby polarity register, reset zero
// (R2) Bits 0-12 set vertical channels 1-13
// (R3) Bits 13-20 gates, bit 21 substrate clock
// (R4) Bits 22-24 bias, shutter, strobe, all standbys
// (R5) 22-bit light standby register, reset 3fe000
// (R6) Bias zero select: plain or XOR shutter zero
// (R7) Bias one select: plain or XOR shutter zero
// (R8) Combine select: shutter zero XOR one or two
// (R9) Software writes test bit 14 as zero
// (R10) 3-bit selector picks field count for trigger
// (R11) Trigger produced only while enable bit set
// (R12) Standby outputs held static at polarity level
// (R13) Software leaves other test fields at reset
`default_nettype none

package sbpm_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 28;
  localparam int unsigned FRAME_W = ADDR_W + DATA_W;
  localparam int unsigned BITS_W  = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] DEEP_POL_ADDR  = 12'h0e2;
  localparam logic [11:0] TEST_A_ADDR    = 12'h0ea;
  localparam logic [11:0] MUX_CFG_ADDR   = 12'h0eb;
  localparam logic [11:0] FIELD_GATE_TRIGGER_PULSE_ADDR   = 12'h0f1;
  localparam logic [11:0] LIGHT_POL_ADDR = 12'h0f3;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned DEEP_POL_W  = 25;
  localparam int unsigned LIGHT_POL_W = 22;
  localparam int unsigned TEST_A_W    = 5;
  localparam int unsigned MUX_CFG_W   = 16;
  localparam int unsigned FIELD_GATE_TRIGGER_PULSE_W   = 4;
  localparam logic [24:0] DEEP_POL_RST  = 25'h0000000;
  localparam logic [21:0] LIGHT_POL_RST = 22'h3fe000;
  localparam logic [4:0]  TEST_A_RST    = 5'h00;
  localparam logic [15:0] MUX_CFG_RST   = 16'h0300;
  localparam logic [3:0]  FIELD_GATE_TRIGGER_PULSE_RST   = 4'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned VCH_LSB     = 0;
  localparam int unsigned VCH_N       = 13;
  localparam int unsigned GATE_LSB    = 13;
  localparam int unsigned GATE_N      = 8;
  localparam int unsigned SUBCK_BIT   = 21;
  localparam int unsigned BIAS_BIT    = 22;
  localparam int unsigned MECHANICAL_SHUTTER_OUTPUT_BIT   = 23;
  localparam int unsigned STROBE_BIT  = 24;
  localparam int unsigned BIAS0_SEL   = 12;
  localparam int unsigned BIAS1_SEL   = 13;
  localparam int unsigned TEST_BIT    = 14;
  localparam int unsigned COMBINE_SEL = 15;
  localparam int unsigned FG_EN_BIT   = 3;
  localparam int unsigned FG_CNT_W    = 3;

  // ----------------------------------------------------------------
  // Standby state codes on the mode input and decoded one-hot states
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_SB1 = 2'h1;
  localparam logic [1:0] MODE_SB2 = 2'h2;

  typedef enum logic [3:0] {
    SBPM_RUN = 4'b0001,
    SBPM_SB1 = 4'b0010,
    SBPM_SB2 = 4'b0100,
    SBPM_SB3 = 4'b1000
  } sbpm_state_e;

  typedef enum logic [1:0] {
    SBPM_RX_IDLE  = 2'b01,
    SBPM_RX_SHIFT = 2'b10
  } sbpm_rx_e;

endpackage

`default_nettype wire

// ---- rtl/sbpm_wr_if.sv ----
`default_nettype none

// Register write strobe from the serial port to the register bank
interface sbpm_wr_if;
  import sbpm_pkg::*;
  logic              wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;

  modport rx   (output wr_stb, output wr_addr, output wr_data);
  modport regs (input wr_stb, input wr_addr, input wr_data);
endinterface

`default_nettype wire

// ---- rtl/sbpm_serial_rx.sv ----
`default_nettype none

module sbpm_serial_rx
  import sbpm_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ser_load_n,
  input  wire logic ser_clk,
  input  wire logic ser_data,
  sbpm_wr_if.rx     wr
);

  sbpm_rx_e                 state_r;
  logic                     ser_clk_r;
  logic [BITS_W-1:0]        count_r;
  logic [FRAME_W-1:0]       shift_r;
  logic                     rise;

  // Rising edge of the serial clock, sampled on mclk
  assign rise = ser_clk & ~ser_clk_r;

  // ----------------------------------------------------------------
  // Frame state and bit shifting, address then data, LSB first
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= SBPM_RX_IDLE;
      ser_clk_r <= 1'b0;
      count_r   <= '0;
      shift_r   <= '0;
    end else begin
      ser_clk_r <= ser_clk;
      case (state_r)
        SBPM_RX_IDLE: begin
          count_r <= '0;
          if (!ser_load_n) begin
            state_r <= SBPM_RX_SHIFT;
          end
        end
        SBPM_RX_SHIFT: begin
          if (ser_load_n) begin
            state_r <= SBPM_RX_IDLE;
          end else if (rise && count_r < BITS_W'(FRAME_W)) begin
            shift_r <= {ser_data, shift_r[FRAME_W-1:1]};
            count_r <= count_r + 1'b1;
          end
        end
        default: state_r <= SBPM_RX_IDLE;
      endcase
    end
  end

  // Write pulse on the cycle after the last frame bit is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr.wr_stb  <= 1'b0;
      wr.wr_addr <= '0;
      wr.wr_data <= '0;
    end else begin
      wr.wr_stb <= (state_r == SBPM_RX_SHIFT) && !ser_load_n && rise &&
                   (count_r == BITS_W'(FRAME_W - 1));
      wr.wr_addr <= {ser_data, shift_r[FRAME_W-1:1]}[ADDR_W-1:0];
      wr.wr_data <= {ser_data, shift_r[FRAME_W-1:1]}[FRAME_W-1:ADDR_W];
    end
  end

endmodule

`default_nettype wire

// ---- rtl/sbpm_top.sv ----
`default_nettype none

module sbpm_top
  import sbpm_pkg::*;
#(
  parameter int unsigned N_VCH  = VCH_N,
  parameter int unsigned N_GATE = GATE_N
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              ser_load_n,
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  input  wire logic [1:0]        standby_mode,
  input  wire logic [N_VCH-1:0]  tg_vertical,
  input  wire logic [N_GATE-1:0] tg_sensor_gate,
  input  wire logic              tg_substrate_clock,
  input  wire logic              bias_signal_zero,
  input  wire logic              bias_signal_one,
  input  wire logic              shutter_signal_zero,
  input  wire logic              shutter_signal_one,
  input  wire logic              shutter_signal_two,
  input  wire logic              tg_strobe,
  input  wire logic [2:0]        mode_field_count,
  input  wire logic              field_start,
  output logic [N_VCH-1:0]       vertical_transfer_channel,
  output logic [N_GATE-1:0]      sensor_gate_output,
  output logic                   substrate_clock_output,
  output logic                   substrate_bias_output_zero,
  output logic                   substrate_bias_output_one,
  output logic                   mechanical_shutter_output,
  output logic                   strobe_output,
  output logic                   field_gate_trigger_pulse
);

  // ----------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------
  logic [DEEP_POL_W-1:0]  deep_standby_output_polarity_r;
  logic [LIGHT_POL_W-1:0] light_standby_output_polarity_r;
  logic [TEST_A_W-1:0]    test_register_a_r;
  logic [MUX_CFG_W-1:0]   test_and_signal_mux_config_r;
  logic [FIELD_GATE_TRIGGER_PULSE_W-1:0]   field_gate_trigger_control_r;
  logic [LIGHT_POL_W-1:0] clock_pol;
  logic                   bias0_path;
  logic                   bias1_path;
  logic                   shutter_combined;
  sbpm_state_e            state;

  sbpm_wr_if wr ();

  // Decodes the standby mode input into a one-hot state
  function automatic sbpm_state_e decode_mode(input logic [1:0] m);
    if (m == MODE_RUN) begin
      return SBPM_RUN;
    end else if (m == MODE_SB1) begin
      return SBPM_SB1;
    end else if (m == MODE_SB2) begin
      return SBPM_SB2;
    end else begin
      return SBPM_SB3;
    end
  endfunction

  // XOR with shutter zero when the select bit is set
  function automatic logic bias_mux(input logic sig, input logic sel,
                                    input logic shut);
    return sel ? (sig ^ shut) : sig;
  endfunction

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  sbpm_serial_rx u_rx (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ser_load_n (ser_load_n),
    .ser_clk    (ser_clk),
    .ser_data   (ser_data),
    .wr         (wr.rx)
  );

  // ----------------------------------------------------------------
  // Register bank, updated as soon as a frame completes
  // ----------------------------------------------------------------

  // Deep standby polarity
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deep_standby_output_polarity_r <= DEEP_POL_RST; // see (R1)
    end else if (wr.wr_stb && wr.wr_addr == DEEP_POL_ADDR) begin
      deep_standby_output_polarity_r <= wr.wr_data[DEEP_POL_W-1:0];
    end
  end

  // Light standby polarity
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      light_standby_output_polarity_r <= LIGHT_POL_RST; // see (R5)
    end else if (wr.wr_stb && wr.wr_addr == LIGHT_POL_ADDR) begin
      light_standby_output_polarity_r <= wr.wr_data[LIGHT_POL_W-1:0];
    end
  end

  // Test register, stored only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      test_register_a_r <= TEST_A_RST;
    end else if (wr.wr_stb && wr.wr_addr == TEST_A_ADDR) begin
      test_register_a_r <= wr.wr_data[TEST_A_W-1:0];
    end
  end

  // Mux configuration; bit 14 is stored as written, no function
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      test_and_signal_mux_config_r <= MUX_CFG_RST;
    end else if (wr.wr_stb && wr.wr_addr == MUX_CFG_ADDR) begin
      test_and_signal_mux_config_r <= wr.wr_data[MUX_CFG_W-1:0];
    end
  end

  // Field gate trigger control
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      field_gate_trigger_control_r <= FIELD_GATE_TRIGGER_PULSE_RST;
    end else if (wr.wr_stb && wr.wr_addr == FIELD_GATE_TRIGGER_PULSE_ADDR) begin
      field_gate_trigger_control_r <= wr.wr_data[FIELD_GATE_TRIGGER_PULSE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Signal muxes and standby selection
  // ----------------------------------------------------------------

  // Bias and shutter combine paths
  assign bias0_path = bias_mux(bias_signal_zero,
    test_and_signal_mux_config_r[BIAS0_SEL], shutter_signal_zero); // see (R6)
  assign bias1_path = bias_mux(bias_signal_one,
    test_and_signal_mux_config_r[BIAS1_SEL], shutter_signal_zero); // see (R7)
  assign shutter_combined = test_and_signal_mux_config_r[COMBINE_SEL] ?
    (shutter_signal_zero ^ shutter_signal_two) :
    (shutter_signal_zero ^ shutter_signal_one); // see (R8)

  // Current state and the clock polarity set that applies to it
  assign state = decode_mode(standby_mode);
  assign clock_pol = (state == SBPM_SB3) ?
    deep_standby_output_polarity_r[LIGHT_POL_W-1:0] :
    light_standby_output_polarity_r;

  // Vertical, gate and substrate clock outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vertical_transfer_channel <= '0;
      sensor_gate_output        <= '0;
      substrate_clock_output    <= 1'b0;
    end else if (state == SBPM_RUN) begin
      vertical_transfer_channel <= tg_vertical;
      sensor_gate_output        <= tg_sensor_gate;
      substrate_clock_output    <= tg_substrate_clock;
    end else begin
      vertical_transfer_channel <=
        clock_pol[VCH_LSB +: N_VCH];           // see (R2) (R12)
      sensor_gate_output <= clock_pol[GATE_LSB +: N_GATE]; // see (R3)
      substrate_clock_output <= clock_pol[SUBCK_BIT];      // see (R3)
    end
  end

  // Bias, shutter and strobe outputs, one level in all standbys
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      substrate_bias_output_zero <= 1'b0;
      substrate_bias_output_one  <= 1'b0;
      mechanical_shutter_output  <= 1'b0;
      strobe_output              <= 1'b0;
    end else if (state == SBPM_RUN) begin
      substrate_bias_output_zero <= bias0_path;
      substrate_bias_output_one  <= bias1_path;
      mechanical_shutter_output  <= shutter_combined;
      strobe_output              <= tg_strobe;
    end else begin
      substrate_bias_output_zero <=
        deep_standby_output_polarity_r[BIAS_BIT];   // see (R4) (R12)
      substrate_bias_output_one <=
        deep_standby_output_polarity_r[BIAS_BIT];   // see (R4)
      mechanical_shutter_output <=
        deep_standby_output_polarity_r[MECHANICAL_SHUTTER_OUTPUT_BIT];  // see (R4)
      strobe_output <=
        deep_standby_output_polarity_r[STROBE_BIT]; // see (R4)
    end
  end

  // Trigger one cycle after each cycle of field start in the selected field
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      field_gate_trigger_pulse <= 1'b0;
    end else begin
      field_gate_trigger_pulse <=
        field_gate_trigger_control_r[FG_EN_BIT] && field_start &&
        (mode_field_count ==
         field_gate_trigger_control_r[FG_CNT_W-1:0]); // see (R10) (R11)
    end
  end

endmodule

`default_nettype wire

// ---- verif/sbpm_top_sva.sv ----
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module sbpm_top_sva
  import sbpm_pkg::*;
#(
  parameter int unsigned N_VCH  = VCH_N,
  parameter int unsigned N_GATE = GATE_N
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              ser_load_n,
  input wire logic              ser_clk,
  input wire logic              ser_data,
  input wire logic [1:0]        standby_mode,
  input wire logic [N_VCH-1:0]  tg_vertical,
  input wire logic [N_GATE-1:0] tg_sensor_gate,
  input wire logic              tg_substrate_clock,
  input wire logic              bias_signal_zero,
  input wire logic              bias_signal_one,
  input wire logic              shutter_signal_zero,
  input wire logic              shutter_signal_one,
  input wire logic              shutter_signal_two,
  input wire logic              tg_strobe,
  input wire logic [2:0]        mode_field_count,
  input wire logic              field_start,
  input wire logic [N_VCH-1:0]  vertical_transfer_channel,
  input wire logic [N_GATE-1:0] sensor_gate_output,
  input wire logic              substrate_clock_output,
  input wire logic              substrate_bias_output_zero,
  input wire logic              substrate_bias_output_one,
  input wire logic              mechanical_shutter_output,
  input wire logic              strobe_output,
  input wire logic              field_gate_trigger_pulse
);
  logic [2:0] quiet_r;

  // Cycles since the serial port was last framed, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) quiet_r <= 3'h0;
    else if (!ser_load_n) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  run_vert_a: assert property (standby_mode == MODE_RUN |=>
    vertical_transfer_channel == $past(tg_vertical))
    else $error("vertical output not passed in run");
  run_gate_a: assert property (standby_mode == MODE_RUN |=>
    sensor_gate_output == $past(tg_sensor_gate))
    else $error("gate output not passed in run");
  bias_zero_a: assert property (standby_mode == MODE_RUN
    && !shutter_signal_zero |=> substrate_bias_output_zero
    == $past(bias_signal_zero)) else $error("bias zero path wrong");
  bias_one_a: assert property (standby_mode == MODE_RUN
    && !shutter_signal_zero |=> substrate_bias_output_one
    == $past(bias_signal_one)) else $error("bias one path wrong");
  shut_comb_a: assert property (standby_mode == MODE_RUN
    && shutter_signal_one == shutter_signal_two |=> mechanical_shutter_output
    == $past(shutter_signal_zero ^ shutter_signal_one))
    else $error("combined shutter wrong");
  sb_bias_a: assert property (standby_mode != MODE_RUN |=>
    substrate_bias_output_zero == substrate_bias_output_one)
    else $error("bias outputs differ in standby");
  sb_static_a: assert property (standby_mode != MODE_RUN
    && $stable(standby_mode) && quiet_r > 3'h4 |=>
    $stable(vertical_transfer_channel) && $stable(strobe_output))
    else $error("standby output toggled");
  trig_cause_a: assert property (field_gate_trigger_pulse |->
    $past(field_start)) else $error("trigger without field start");

  cover property (field_gate_trigger_pulse);
  cover property (standby_mode == 2'h3 && quiet_r == 3'h7);
  cover property (standby_mode == MODE_RUN && shutter_signal_zero);
endmodule

bind sbpm_top sbpm_top_sva #(.N_VCH(N_VCH), .N_GATE(N_GATE)) u_sva (
  .mclk(mclk), .rst_n(rst_n), .ser_load_n(ser_load_n), .ser_clk(ser_clk),
  .ser_data(ser_data), .standby_mode(standby_mode),
  .tg_vertical(tg_vertical), .tg_sensor_gate(tg_sensor_gate),
  .tg_substrate_clock(tg_substrate_clock), .tg_strobe(tg_strobe),
  .bias_signal_zero(bias_signal_zero), .bias_signal_one(bias_signal_one),
  .shutter_signal_zero(shutter_signal_zero),
  .shutter_signal_one(shutter_signal_one),
  .shutter_signal_two(shutter_signal_two),
  .mode_field_count(mode_field_count), .field_start(field_start),
  .vertical_transfer_channel(vertical_transfer_channel),
  .sensor_gate_output(sensor_gate_output),
  .substrate_clock_output(substrate_clock_output),
  .substrate_bias_output_zero(substrate_bias_output_zero),
  .substrate_bias_output_one(substrate_bias_output_one),
  .mechanical_shutter_output(mechanical_shutter_output),
  .strobe_output(strobe_output),
  .field_gate_trigger_pulse(field_gate_trigger_pulse));

`default_nettype wire

// ---- verif/sbpm_sensor_model.sv ----
`default_nettype none
// Shutter and strobe hardware: counts field gate trigger pulses it sees
module sbpm_sensor_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        field_gate_trigger_pulse,
  output logic [15:0]      trig_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // One count per cycle that the pulse is high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) trig_seen <= 16'h0000;
    else if (field_gate_trigger_pulse) trig_seen <= trig_seen + 16'h0001;
  end
endmodule
`default_nettype wire

// ---- verif/sbpm_top_tb.sv ----
`default_nettype none
module sbpm_top_tb
  import sbpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, ser_load_n, ser_clk, ser_data, tg_subck, tg_strobe;
  logic        b0, b1, s0, s1, s2, field_start, o_subck, o_b0, o_b1, o_msh;
  logic        o_strb, o_trig;
  logic [1:0]  mode;
  logic [12:0] tg_v, o_v;
  logic [7:0]  tg_g, o_g;
  logic [2:0]  fcnt;
  logic [15:0] trig_seen, m_mux;
  logic [24:0] m_deep;
  logic [21:0] m_light;
  logic [3:0]  m_trig;
  int          fail_count, tests_run, m_trigs;
  wire  [26:0] got = {o_v, o_g, o_subck, o_b0, o_b1, o_msh, o_strb, o_trig};

  sbpm_top dut (.mclk(mclk), .rst_n(rst_n), .ser_load_n(ser_load_n),
    .ser_clk(ser_clk), .ser_data(ser_data), .standby_mode(mode),
    .tg_vertical(tg_v), .tg_sensor_gate(tg_g), .tg_substrate_clock(tg_subck),
    .bias_signal_zero(b0), .bias_signal_one(b1), .shutter_signal_zero(s0),
    .shutter_signal_one(s1), .shutter_signal_two(s2), .tg_strobe(tg_strobe),
    .mode_field_count(fcnt), .field_start(field_start),
    .vertical_transfer_channel(o_v), .sensor_gate_output(o_g),
    .substrate_clock_output(o_subck), .substrate_bias_output_zero(o_b0),
    .substrate_bias_output_one(o_b1), .mechanical_shutter_output(o_msh),
    .strobe_output(o_strb), .field_gate_trigger_pulse(o_trig));
  sbpm_sensor_model u_sensor (.mclk(mclk), .rst_n(rst_n),
    .field_gate_trigger_pulse(o_trig), .trig_seen(trig_seen));

  // ----------------------------------------
  // Clock, compare and model
  // ----------------------------------------
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  task automatic chk(input string what, input logic [26:0] exp, seen);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected outputs one edge after the current inputs
  function automatic logic [26:0] expect_out();
    logic [21:0] pol;
    logic [26:0] r;
    pol = (mode == 2'h3) ? m_deep[21:0] : m_light;
    if (mode == 2'h0)
      r = {tg_v, tg_g, tg_subck, b0 ^ (m_mux[12] & s0), b1 ^ (m_mux[13] & s0),
           s0 ^ (m_mux[15] ? s2 : s1), tg_strobe, 1'b0};
    else
      r = {pol[12:0], pol[20:13], pol[21], m_deep[22], m_deep[22],
           m_deep[23], m_deep[24], 1'b0};
    r[0] = field_start & m_trig[3] & (fcnt == m_trig[2:0]);
    return r;
  endfunction

  // Random inputs at one falling edge, compared at the next
  task automatic step(input logic [1:0] md);
    logic [26:0] e;
    {tg_v, tg_g, tg_subck, b0, b1, s0, s1, s2, tg_strobe} = 28'($urandom);
    fcnt = 3'($urandom);
    field_start = 1'($urandom);
    mode = md;
    e = expect_out();
    @(negedge mclk);
    chk("outputs", e, got);
    if (e[0]) m_trigs++;
  endtask

  // One serial frame: address then data, least significant bit first
  task automatic wr(input logic [11:0] a, input logic [27:0] d);
    logic [39:0] f;
    f = {d, a};
    ser_load_n = 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 40; i++) begin
      ser_data = f[i];
      ser_clk = 1'b1;
      @(negedge mclk);
      ser_clk = 1'b0;
      @(negedge mclk);
    end
    ser_load_n = 1'b1;
    ser_data = ~ser_data;
    repeat (4) @(negedge mclk);
    case (a)
      12'h0e2: m_deep = d[24:0];
      12'h0eb: m_mux = d[15:0];
      12'h0f1: m_trig = d[3:0];
      12'h0f3: m_light = d[21:0];
      default: ;
    endcase
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    {m_deep, m_light, m_mux, m_trig} = {25'h0, 22'h3fe000, 16'h0300, 4'h0};
  endtask

  task automatic finish_test();
    $display("counts: tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, ser_clk, ser_data, field_start, mode, fcnt} = '0;
    {tg_v, tg_g, tg_subck, b0, b1, s0, s1, s2, tg_strobe} = '0;
    ser_load_n = 1'b1;
    void'($urandom(32'h8d9f8ca1));
    @(negedge mclk);
    do_reset();
    for (int m = 0; m < 4; m++) repeat (4) step(2'(m));
    $display("test reset_values done");
    wr(DEEP_POL_ADDR, 28'($urandom));
    wr(LIGHT_POL_ADDR, 28'($urandom));
    wr(12'h0e3, 28'hfffffff);
    for (int m = 0; m < 4; m++) repeat (6) step(2'(m));
    $display("test polarity done");
    for (int k = 0; k < 8; k++) begin
      wr(MUX_CFG_ADDR, {12'h0, k[2], 1'b0, k[1:0], 12'h300});
      repeat (8) step(2'($urandom));
    end
    $display("test mux_select done");
    for (int k = 0; k < 9; k++) begin
      wr(FIELD_GATE_TRIGGER_PULSE_ADDR, {24'h0, k < 8, 3'(k)});
      repeat (32) step(2'($urandom));
    end
    chk("trigger count", 27'(m_trigs), 27'(trig_seen));
    $display("test trigger done");
    do_reset();
    for (int m = 0; m < 4; m++) repeat (3) step(2'(m));
    $display("test second_reset done");
    finish_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(1_000_000);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
